// ---- src/rx_path_status_and_events.sv ----
// Decided for this implementation: the plain strobed port.
`timescale 1ns/1ps
`default_nettype none
`include "rxps_regs.svh"
module rx_path_status_and_events #(
  parameter int NBUF = 8
) (
  // Clock and reset
  input  wire logic                   sys_clk,
  input  wire logic                   rstn,
  // Register port
  input  wire logic [11:0]            reg_addr,
  input  wire logic [31:0]            reg_wdata,
  input  wire logic                   reg_wr,
  input  wire logic                   reg_rd,
  output logic [31:0]                 reg_rdata,
  // Stream inputs
  input  wire rxps_pkg::rxps_stream_t strm_a,
  input  wire rxps_pkg::rxps_stream_t strm_b,
  // Buffer configuration
  input  wire logic [NBUF-1:0]        buf_is_vid_a,
  input  wire logic [NBUF-1:0]        buf_is_vid_b,
  // Receive events
  input  wire rxps_pkg::rxps_events_t evt,
  // Packet abort request to the receive engine
  output logic                        pkt_abort,
  // Summary interrupts
  output logic                        receive_summary_high,
  output logic                        receive_summary_low
);
  logic [1:0]  mode_a;
  logic [1:0]  mode_b;
  logic        par_a;
  logic        par_b;
  logic        tog_a;
  logic        tog_b;
  logic        mis_a;
  logic        mis_b;
  logic        conflict;
  logic        conflict_r;
  logic [31:0] flags_r;
  logic [31:0] flags_nxt;
  logic [31:0] enables_r;
  logic [31:0] set_vec;
  logic [31:0] state_word;
  logic        evt_rd;

  // ----------------------------------------------------------------
  // Stream trackers and buffer conflict check
  // ----------------------------------------------------------------
  rxps_stream_track u_trk_a (
    .sys_clk       (sys_clk),
    .rstn          (rstn),
    .strm          (strm_a),
    .mode_r        (mode_a),
    .parity_r      (par_a),
    .parity_toggle (tog_a),
    .mode_mismatch (mis_a)
  );

  rxps_stream_track u_trk_b (
    .sys_clk       (sys_clk),
    .rstn          (rstn),
    .strm          (strm_b),
    .mode_r        (mode_b),
    .parity_r      (par_b),
    .parity_toggle (tog_b),
    .mode_mismatch (mis_b)
  );

  rxps_conflict #(.NBUF(NBUF)) u_confl (
    .buf_is_vid_a (buf_is_vid_a),
    .buf_is_vid_b (buf_is_vid_b),
    .conflict     (conflict)
  );

  always_ff @(posedge sys_clk) begin
    if (!rstn) begin
      conflict_r <= 1'b0;
    end else begin
      conflict_r <= conflict;
    end
  end

  // ----------------------------------------------------------------
  // Event set vector
  // ----------------------------------------------------------------
  always_comb begin
    set_vec        = 32'h0;
    set_vec[31:24] = evt.buf_abort;
    set_vec[23:16] = evt.buf_confirm;
    set_vec[15]    = tog_b;
    set_vec[14]    = tog_a;
    set_vec[13]    = mis_b;
    set_vec[12]    = mis_a;
    set_vec[11]    = strm_b.split_fault;
    set_vec[10]    = strm_a.split_fault;
    set_vec[9]     = strm_b.seq_fault;
    set_vec[8]     = strm_a.seq_fault;
    set_vec[6]     = evt.busy_ack_sent;
    set_vec[5]     = evt.payload_check_fail;
    set_vec[4]     = evt.no_target_buffer;
    set_vec[3]     = evt.illegal_transaction_code;
    set_vec[2]     = evt.receiver_busied_off;
    set_vec[1]     = evt.quad_write
                     && (evt.quad_addr == `RXPS_RESET_CSR);
    set_vec[0]     = evt.self_identify_done;
  end

  // ----------------------------------------------------------------
  // Event flags: clear on read, set wins
  // ----------------------------------------------------------------
  assign evt_rd = reg_rd && (reg_addr == `RXPS_EVENT_OFS);

  always_comb begin
    flags_nxt = evt_rd ? 32'h0 : flags_r;
    flags_nxt = (flags_nxt | set_vec) & `RXPS_EVT_MASK;
  end

  always_ff @(posedge sys_clk) begin
    if (!rstn) begin
      flags_r <= `RXPS_RESET_WORD;
    end else begin
      flags_r <= flags_nxt;
    end
  end

  // Enables live at the next word; reserved bit 7 stays zero
  always_ff @(posedge sys_clk) begin
    if (!rstn) begin
      enables_r <= `RXPS_RESET_WORD;
    end else if (reg_wr && (reg_addr == `RXPS_ENABLE_OFS)) begin
      enables_r <= reg_wdata & `RXPS_EVT_MASK;
    end
  end

  // Abort the packet on address or transaction code faults
  always_ff @(posedge sys_clk) begin
    if (!rstn) begin
      pkt_abort <= 1'b0;
    end else begin
      pkt_abort <= evt.no_target_buffer
                   || evt.illegal_transaction_code;
    end
  end

  // ----------------------------------------------------------------
  // Summary interrupts, registered from the next flag value
  // ----------------------------------------------------------------
  always_ff @(posedge sys_clk) begin
    if (!rstn) begin
      receive_summary_high <= 1'b0;
      receive_summary_low  <= 1'b0;
    end else begin
      receive_summary_high <= |(flags_nxt & enables_r
                                & `RXPS_HI_MASK);
      receive_summary_low  <= |(flags_nxt & enables_r
                                & `RXPS_LO_MASK);
    end
  end

  // ----------------------------------------------------------------
  // Read path
  // ----------------------------------------------------------------
  always_comb begin
    state_word = 32'h0;
    state_word[`RXPS_MODE_B_HI:`RXPS_MODE_B_LO] = mode_b;
    state_word[`RXPS_MODE_A_HI:`RXPS_MODE_A_LO] = mode_a;
    state_word[`RXPS_PAR_A_BIT] = par_a;
    state_word[`RXPS_PAR_B_BIT] = par_b;
    state_word[`RXPS_CONFL_BIT] = conflict_r;
  end

  // Unmapped addresses read zero; writes to read-only words are dropped
  always_ff @(posedge sys_clk) begin
    if (!rstn) begin
      reg_rdata <= `RXPS_RESET_WORD;
    end else if (reg_rd) begin
      if (reg_addr == `RXPS_STATE_OFS) begin
        reg_rdata <= state_word;
      end else if (reg_addr == `RXPS_EVENT_OFS) begin
        reg_rdata <= flags_r;
      end else if (reg_addr == `RXPS_ENABLE_OFS) begin
        reg_rdata <= enables_r;
      end else begin
        reg_rdata <= 32'h0;
      end
    end else begin
      reg_rdata <= 32'h0;
    end
  end
endmodule // rx_path_status_and_events
`default_nettype wire

// ---- src/rxps_regs.svh ----
`ifndef RXPS_REGS_SVH
`define RXPS_REGS_SVH

// ----------------------------------------------------------------
// Register offsets
// ----------------------------------------------------------------
`define RXPS_STATE_OFS   12'h344
`define RXPS_EVENT_OFS   12'h348
`define RXPS_ENABLE_OFS  12'h34C

// ----------------------------------------------------------------
// Field positions and masks
// ----------------------------------------------------------------
`define RXPS_MODE_B_HI   15
`define RXPS_MODE_B_LO   14
`define RXPS_MODE_A_HI   13
`define RXPS_MODE_A_LO   12
`define RXPS_PAR_A_BIT   11
`define RXPS_PAR_B_BIT   10
`define RXPS_CONFL_BIT   0
`define RXPS_EVT_MASK    32'hFFFF_FF7F
`define RXPS_HI_MASK     32'hFFFF_0000
`define RXPS_LO_MASK     32'h0000_FF7F
`define RXPS_RESET_WORD  32'h0000_0000
`define RXPS_RESET_CSR   48'hFFFF_F000_000C

`endif

// ---- src/rxps_pkg.sv ----
package rxps_pkg;
  // Per-stream copy mode and parity inputs
  typedef struct packed {
    logic       pkt_valid;
    logic [1:0] copy_mode;
    logic [1:0] cipher_mode;
    logic       key_parity;
    logic       split_fault;
    logic       seq_fault;
  } rxps_stream_t;

  // Single-cycle receive events from the packet engine
  typedef struct packed {
    logic [7:0]  buf_abort;
    logic [7:0]  buf_confirm;
    logic        busy_ack_sent;
    logic        payload_check_fail;
    logic        no_target_buffer;
    logic        illegal_transaction_code;
    logic        receiver_busied_off;
    logic        quad_write;
    logic [47:0] quad_addr;
    logic        self_identify_done;
  } rxps_events_t;

  typedef enum logic [2:0] {
    RXPS_TRK_IDLE  = 3'b001,
    RXPS_TRK_LIVE  = 3'b010,
    RXPS_TRK_CHECK = 3'b100
  } rxps_trk_t;
endpackage : rxps_pkg

// ---- src/rxps_stream_track.sv ----
`timescale 1ns/1ps
`default_nettype none
`include "rxps_regs.svh"
module rxps_stream_track (
  // Clock and reset
  input  wire logic                  sys_clk,
  input  wire logic                  rstn,
  // Stream input
  input  wire rxps_pkg::rxps_stream_t strm,
  // State and event pulses
  output logic [1:0]                 mode_r,
  output logic                       parity_r,
  output logic                       parity_toggle,
  output logic                       mode_mismatch
);
  rxps_pkg::rxps_trk_t st_r;

  // ----------------------------------------------------------------
  // Tracking; the first packet after reset sets the baseline only
  // ----------------------------------------------------------------
  always_ff @(posedge sys_clk) begin
    if (!rstn) begin
      st_r <= rxps_pkg::RXPS_TRK_IDLE;
    end else begin
      case (st_r)
        rxps_pkg::RXPS_TRK_IDLE:  if (strm.pkt_valid) st_r <= rxps_pkg::RXPS_TRK_LIVE;
        rxps_pkg::RXPS_TRK_LIVE:  st_r <= rxps_pkg::RXPS_TRK_LIVE;
        default:                  st_r <= rxps_pkg::RXPS_TRK_IDLE;
      endcase
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!rstn) begin
      mode_r   <= 2'h0;
      parity_r <= 1'h0;
    end else if (strm.pkt_valid) begin
      mode_r   <= strm.copy_mode;
      parity_r <= strm.key_parity;
    end
  end

  // Toggle only counts once a baseline parity exists
  assign parity_toggle = strm.pkt_valid && (st_r == rxps_pkg::RXPS_TRK_LIVE)
                         && (strm.key_parity != parity_r);
  assign mode_mismatch = strm.pkt_valid
                         && (strm.copy_mode != strm.cipher_mode);
endmodule // rxps_stream_track
`default_nettype wire

// ---- src/rxps_conflict.sv ----
`timescale 1ns/1ps
`default_nettype none
module rxps_conflict #(
  parameter int NBUF = 8
) (
  // Buffer video type selections
  input  wire logic [NBUF-1:0] buf_is_vid_a,
  input  wire logic [NBUF-1:0] buf_is_vid_b,
  // Result
  output logic                 conflict
);
  function automatic logic multi(input logic [NBUF-1:0] v);
    return (v & (v - 1'b1)) != '0;
  endfunction

  // Level only; the register stage sits in the top
  assign conflict = multi(buf_is_vid_a) || multi(buf_is_vid_b);
endmodule // rxps_conflict
`default_nettype wire

// ---- sim/rxps_monitor.sv ----
`timescale 1ns/1ps
`default_nettype none
module rxps_monitor #(
  parameter int NBUF = 8
) (
  // Clock, reset, register port
  input wire logic                   sys_clk,
  input wire logic                   rstn,
  input wire logic [11:0]            reg_addr,
  input wire logic                   reg_wr,
  input wire logic                   reg_rd,
  input wire logic [31:0]            reg_rdata,
  // Stimulus
  input wire rxps_pkg::rxps_stream_t strm_a,
  input wire rxps_pkg::rxps_stream_t strm_b,
  input wire rxps_pkg::rxps_events_t evt,
  // Results
  input wire logic                   pkt_abort,
  input wire logic                   receive_summary_high,
  input wire logic                   receive_summary_low
);
  logic rd_st, rd_ev, low_in;
  assign rd_st = reg_rd && reg_addr == 12'h344;
  assign rd_ev = reg_rd && reg_addr == 12'h348;
  // Every input able to raise the low summary
  assign low_in = reg_wr | evt.busy_ack_sent | evt.payload_check_fail
    | evt.no_target_buffer | evt.illegal_transaction_code
    | evt.receiver_busied_off | evt.quad_write | evt.self_identify_done
    | strm_a.pkt_valid | strm_a.split_fault | strm_a.seq_fault
    | strm_b.pkt_valid | strm_b.split_fault | strm_b.seq_fault;
  // ----------------------------------------------------------------
  // Properties
  // ----------------------------------------------------------------
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rstn);
  property p_abort_addr;
    evt.no_target_buffer |=> pkt_abort;
  endproperty
  a_abort_addr: assert property (p_abort_addr) else $error("no abort");
  property p_abort_code;
    evt.illegal_transaction_code |=> pkt_abort;
  endproperty
  a_abort_code: assert property (p_abort_code) else $error("no abort");
  property p_st_rsvd;
    rd_st |=> reg_rdata[31:16] == 16'h0000 && reg_rdata[9:1] == 9'h000;
  endproperty
  a_st_rsvd: assert property (p_st_rsvd) else $error("state reserved");
  property p_mode_a;
    strm_a.pkt_valid ##1 rd_st |=> reg_rdata[13:12] == $past(strm_a.copy_mode, 2);
  endproperty
  a_mode_a: assert property (p_mode_a) else $error("mode a wrong");
  property p_crc;
    evt.payload_check_fail ##1 rd_ev |=> reg_rdata[5];
  endproperty
  a_crc: assert property (p_crc) else $error("crc flag lost");
  property p_conf;
    evt.buf_confirm != 8'h00 ##1 rd_ev |=>
      (reg_rdata[23:16] & $past(evt.buf_confirm, 2)) == $past(evt.buf_confirm, 2);
  endproperty
  a_conf: assert property (p_conf) else $error("confirm flag lost");
  // An enable write reaches the summary one edge later than an event
  property p_low;
    $rose(receive_summary_low) |-> $past(low_in) || $past(reg_wr, 2);
  endproperty
  a_low: assert property (p_low) else $error("low summary uncaused");
  property p_high;
    $rose(receive_summary_high) |-> $past(reg_wr, 2) ||
      $past(evt.buf_abort != 8'h00 || evt.buf_confirm != 8'h00);
  endproperty
  a_high: assert property (p_high) else $error("high summary uncaused");
  property p_clr;
    rd_ev && !low_in |=> !receive_summary_low;
  endproperty
  a_clr: assert property (p_clr) else $error("read left summary");
endmodule // rxps_monitor
bind rx_path_status_and_events rxps_monitor #(.NBUF(NBUF)) mon (
  .sys_clk              (sys_clk),
  .rstn                 (rstn),
  .reg_addr             (reg_addr),
  .reg_wr               (reg_wr),
  .reg_rd               (reg_rd),
  .reg_rdata            (reg_rdata),
  .strm_a               (strm_a),
  .strm_b               (strm_b),
  .evt                  (evt),
  .pkt_abort            (pkt_abort),
  .receive_summary_high (receive_summary_high),
  .receive_summary_low  (receive_summary_low)
);
`default_nettype wire

// ---- sim/rxps_host_model.sv ----
`timescale 1ns/1ps
`default_nettype none
module rxps_host_model (
  // Clock
  input  wire logic       sys_clk,
  // Register port master
  output var logic [11:0] reg_addr,
  output var logic [31:0] reg_wdata,
  output var logic        reg_wr,
  output var logic        reg_rd
);
  initial begin
    reg_addr  = 12'h000;
    reg_wdata = 32'h0000_0000;
    reg_wr    = 1'b0;
    reg_rd    = 1'b0;
  end
  // Idle edge after each access so a strobe never drops and rises at once
  task automatic acc(input logic w, input logic [11:0] a,
                     input logic [31:0] d);
    reg_addr  <= a;
    reg_wdata <= d;
    reg_wr    <= w;
    reg_rd    <= !w;
    @(posedge sys_clk);
    reg_wr <= 1'b0;
    reg_rd <= 1'b0;
    @(posedge sys_clk);
  endtask
endmodule // rxps_host_model
`default_nettype wire

// ---- sim/tb_top.sv ----
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  logic                   sys_clk, rstn, reg_wr, reg_rd, rd_seen;
  logic                   pkt_abort, receive_summary_high, receive_summary_low;
  logic [11:0]            reg_addr, a;
  logic [31:0]            reg_wdata, reg_rdata, r;
  logic [7:0]             buf_is_vid_a, buf_is_vid_b;
  logic [1:0]             md [2];
  logic [16:0]            cfg [3] = '{17'h1_0500, 17'h1_0181, 17'h0_0102};
  rxps_pkg::rxps_stream_t strm_a, strm_b, st, z;
  rxps_pkg::rxps_events_t evt, e;
  logic [31:0]            exp_q [$];
  int                     bad_count = 0, checked = 0, cyc = 0, seed, s, j;
  rx_path_status_and_events dut (
    .sys_clk              (sys_clk),
    .rstn                 (rstn),
    .reg_addr             (reg_addr),
    .reg_wdata            (reg_wdata),
    .reg_wr               (reg_wr),
    .reg_rd               (reg_rd),
    .reg_rdata            (reg_rdata),
    .strm_a               (strm_a),
    .strm_b               (strm_b),
    .buf_is_vid_a         (buf_is_vid_a),
    .buf_is_vid_b         (buf_is_vid_b),
    .evt                  (evt),
    .pkt_abort            (pkt_abort),
    .receive_summary_high (receive_summary_high),
    .receive_summary_low  (receive_summary_low)
  );
  rxps_host_model host (
    .sys_clk   (sys_clk),
    .reg_addr  (reg_addr),
    .reg_wdata (reg_wdata),
    .reg_wr    (reg_wr),
    .reg_rd    (reg_rd)
  );
  initial begin
    sys_clk = 1'b0;
    forever #4 sys_clk = ~sys_clk;
  end
  task automatic chk(input logic [31:0] seen, input logic [31:0] x);
    checked++;
    if (seen !== x) begin
      bad_count++;
      $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, x);
    end
  endtask
  task automatic rd(input logic [11:0] ad, input logic [31:0] x);
    exp_q.push_back(x);
    host.acc(1'b0, ad, 32'h0000_0000);
  endtask
  task automatic fire(input rxps_pkg::rxps_events_t ev,
                      input rxps_pkg::rxps_stream_t sa, sb);
    evt    <= ev;
    strm_a <= sa;
    strm_b <= sb;
    @(posedge sys_clk);
    evt    <= '0;
    strm_a <= '0;
    strm_b <= '0;
    #1;
  endtask
  task automatic end_sim;
    $display("checks %0d mismatches %0d", checked, bad_count);
    if (bad_count == 0 && checked > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask
  always @(posedge sys_clk) rd_seen <= reg_rd;
  always @(negedge sys_clk) if (rd_seen) chk(reg_rdata, exp_q.pop_front());
  always @(posedge sys_clk) begin
    cyc <= cyc + 1;
    if (cyc == 3000) begin
      bad_count++;
      end_sim;
    end
  end
  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  initial begin
    seed = 57;
    rstn = 1'b0;
    z = '0;
    strm_a = '0;
    strm_b = '0;
    evt = '0;
    buf_is_vid_a = 8'h00;
    buf_is_vid_b = 8'h00;
    repeat (16) @(posedge sys_clk);
    rstn <= 1'b1;
    @(posedge sys_clk);
    for (a = 12'h344; a <= 12'h350; a += 12'h004) rd(a, 32'h0000_0000);
    for (a = 12'h344; a <= 12'h34C; a += 12'h004) host.acc(1'b1, a, 32'hFFFF_FFFF);
    rd(12'h344, 32'h0000_0000);
    rd(12'h348, 32'h0000_0000);
    rd(12'h34C, 32'hFFFF_FF7F);
    $display("test registers done");
    for (j = 0; j < 7; j++) begin
      e = 71'h1 << ((j == 0) ? 0 : 48 + j);
      if (j == 1) e.quad_addr = 48'hFFFF_F000_000C;
      fire(e, z, z);
      chk({31'h0, receive_summary_low}, 32'h1);
      chk({31'h0, pkt_abort}, {31'h0, j == 3 || j == 4});
      rd(12'h348, 32'h1 << j);
      rd(12'h348, 32'h0);
    end
    e = '0;
    e.quad_write = 1'b1;
    e.quad_addr = 48'hFFFF_F000_0010;
    fire(e, z, z);
    rd(12'h348, 32'h0);
    e = '0;
    $display("test events done");
    for (s = 0; s < 2; s++) begin
      r = $random(seed);
      md[s] = r[1:0];
      // First packet sets the parity baseline, so no toggle flag yet
      st = '{1'h1, md[s], ~md[s], 1'h1, 1'h1, 1'h1};
      fire(e, s ? z : st, s ? st : z);
      r = {16'h0, s ? md[1] : 2'h0, md[0], s == 0, s == 1, 10'h0};
      rd(12'h344, r);
      rd(12'h348, 32'h0000_1500 << s);
      st = '{1'h1, md[s], md[s], 1'h0, 1'h0, 1'h0};
      fire(e, s ? z : st, s ? st : z);
      rd(12'h348, 32'h0000_4000 << s);
    end
    for (j = 0; j < 3; j++) begin
      buf_is_vid_a <= cfg[j][15:8];
      buf_is_vid_b <= cfg[j][7:0];
      repeat (2) @(posedge sys_clk);
      rd(12'h344, {16'h0, md[1], md[0], 2'h0, 9'h0, cfg[j][16]});
    end
    $display("test streams done");
    r = $random(seed);
    e.buf_abort = r[7:0];
    e.buf_confirm = r[15:8];
    fire(e, z, z);
    chk({31'h0, receive_summary_high}, {31'h0, |r[15:0]});
    rd(12'h348, {r[7:0], r[15:8], 16'h0});
    e = '0;
    e.payload_check_fail = 1'b1;
    host.acc(1'b1, 12'h34C, 32'h0000_0000);
    fire(e, z, z);
    chk({31'h0, receive_summary_low}, 32'h0);
    fork
      fire(e, z, z);
      rd(12'h348, 32'h0000_0020);
    join
    rd(12'h348, 32'h0000_0020);
    rd(12'h348, 32'h0000_0000);
    $display("test clear done");
    end_sim;
  end
endmodule // tb_top
`default_nettype wire
